//--- dpm_core_model.sv
`timescale 1ns/1ps
// processor core side: one request per cycle, driven at the falling edge
module dpm_core_model (
  input wire logic sys_clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd,
  output logic bit_wr,
  output logic bit_wval,
  output logic bit_rd,
  output logic dptr_load,
  output logic [15:0] dptr_wdata,
  output logic dptr_inc,
  output logic movx_req,
  output logic movx_use_dptr,
  output logic [15:0] code_addr,
  output logic idata_indirect,
  output logic [3:0] op
);
  // every strobe is assigned once per call, so back to back requests never glitch
  task automatic set(input logic [3:0] k, input logic [7:0] a, input logic [15:0] d);
    sfr_wr = k == 4'h1;
    sfr_rd = k == 4'h2;
    bit_wr = k == 4'h3;
    bit_rd = k == 4'h4;
    dptr_load = k == 4'h5;
    dptr_inc = k == 4'h6;
    movx_req = k == 4'h7 || k == 4'h8;
    movx_use_dptr = k == 4'h8;
    sfr_addr = a;
    sfr_wdata = d[7:0];
    bit_wval = d[0];
    dptr_wdata = d;
    code_addr = d;
    idata_indirect = d[0];
    op = k;
  endtask
  task automatic go(input logic [3:0] k, input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    set(k, a, d);
  endtask
  initial set(4'h0, 8'h00, 16'h0000);
endmodule

//--- dpm_map_if.sv
`timescale 1ns/1ps
interface dpm_map_if;
  logic [15:0] code_addr;
  logic [7:0] idata_addr;
  logic idata_indirect;
  logic [15:0] xdata_addr;
  logic flash_hit;
  logic xram_hit;
  logic iram_lo;
  logic iram_hi;
  logic sfr_hit;

  modport regs (
    output code_addr,
    output idata_addr,
    output idata_indirect,
    output xdata_addr,
    input flash_hit,
    input xram_hit,
    input iram_lo,
    input iram_hi,
    input sfr_hit
  );

  modport dec (
    input code_addr,
    input idata_addr,
    input idata_indirect,
    input xdata_addr,
    output flash_hit,
    output xram_hit,
    output iram_lo,
    output iram_hi,
    output sfr_hit
  );
endinterface

//--- dpm_pkg.sv
package dpm_pkg;

  // direct special function addresses
  localparam logic [7:0] DPM_ADDR_PTR_A_LOW = 8'h82;
  localparam logic [7:0] DPM_ADDR_PTR_A_HIGH = 8'h83;
  localparam logic [7:0] DPM_ADDR_PTR_B_LOW = 8'h84;
  localparam logic [7:0] DPM_ADDR_PTR_B_HIGH = 8'h85;
  localparam logic [7:0] DPM_ADDR_PTR_SELECT = 8'h86;
  localparam logic [7:0] DPM_ADDR_PAGE_HIGH = 8'hcf;
  localparam logic [7:0] DPM_ADDR_SOFT_FLAGS = 8'hf8;

  // field positions
  localparam int DPM_SEL_BIT = 0;
  localparam logic [7:0] DPM_SELECT_MASK = 8'h01;
  localparam int DPM_HIGH_MSB = 15;
  localparam int DPM_HIGH_LSB = 8;
  localparam int DPM_LOW_MSB = 7;
  localparam int DPM_LOW_LSB = 0;

  // bit addresses f8h..ffh land on the software flag byte
  localparam logic [4:0] DPM_FLAG_BIT_BASE = 5'h1f;

  // memory sizes
  localparam logic [16:0] DPM_FLASH_BYTES = 17'he000;
  localparam logic [16:0] DPM_XRAM_BYTES = 17'h00400;
  localparam logic [7:0] DPM_IRAM_HALF = 8'h80;

  // reset values
  localparam logic [15:0] DPM_PTR_RESET = 16'h0000;
  localparam logic DPM_SEL_RESET = 1'b0;
  localparam logic [7:0] DPM_PAGE_RESET = 8'h00;
  localparam logic [7:0] DPM_FLAGS_RESET = 8'h00;

  typedef struct packed {
    logic [15:0] ptr_a;
    logic [15:0] ptr_b;
    logic sel;
    logic [7:0] page;
    logic [7:0] flags;
    logic [7:0] rdata;
    logic claim;
    logic bit_rdata;
    logic [15:0] dptr_addr;
    logic [15:0] ext_addr;
    logic flash_hit;
    logic xram_hit;
    logic iram_lo;
    logic iram_hi;
    logic sfr_hit;
  } dpm_state_s;

  localparam dpm_state_s DPM_STATE_RESET = '{
    ptr_a: DPM_PTR_RESET,
    ptr_b: DPM_PTR_RESET,
    sel: DPM_SEL_RESET,
    page: DPM_PAGE_RESET,
    flags: DPM_FLAGS_RESET,
    rdata: 8'h00,
    claim: 1'b0,
    bit_rdata: 1'b0,
    dptr_addr: 16'h0000,
    ext_addr: 16'h0000,
    flash_hit: 1'b1,
    xram_hit: 1'b1,
    iram_lo: 1'b0,
    iram_hi: 1'b0,
    sfr_hit: 1'b0
  };

endpackage

//--- dpm_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - after reset code runs from on-chip flash covering program space 0000h to dfffh
// - one kilobyte ram sits in external data space for general storage
// - 256 byte internal ram; upper half indirect only, lower half direct or indirect
// - sfrs fill upper 128 addresses, direct only; indirect there reaches upper ram
// - first pointer low byte at 82h, high byte at 83h
// - second pointer low byte at 84h, high byte at 85h
// - select 0 uses first pointer pair, select 1 uses second pair
// - select bit is bit 0 of the select register at 86h
// - select register bits 7 to 1 always read zero
// - all pointer instructions act on selected pointer only, other stays untouched
// - incrementing the select register toggles the select bit, upper bits stay zero
// - pointer address is high byte on bits 15-8, low byte on 7-0
// - non-pointer external moves take upper address byte from page register at cfh
// - software flag register at f8h also works as byte storage
// - each flag bit readable, settable and clearable by bit access and byte access
module dpm_regs
  import dpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata_r,
  output logic sfr_claim_r,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_wval,
  input wire logic bit_rd,
  output logic bit_rdata_r,
  input wire logic dptr_load,
  input wire logic [15:0] dptr_wdata,
  input wire logic dptr_inc,
  output logic [15:0] dptr_addr_r,
  input wire logic movx_req,
  input wire logic movx_use_dptr,
  input wire logic [7:0] movx_ri,
  output logic [15:0] ext_addr_r,
  output logic xram_hit_r,
  input wire logic [15:0] code_addr,
  output logic flash_hit_r,
  input wire logic [7:0] idata_addr,
  input wire logic idata_indirect,
  output logic iram_lo_r,
  output logic iram_hi_r,
  output logic sfr_space_r
);

  dpm_state_s st_r;
  dpm_state_s st_nxt;
  dpm_map_if map ();

  function automatic logic [15:0] active_ptr(input dpm_state_s s);
    active_ptr = s.sel ? s.ptr_b : s.ptr_a;
  endfunction

  function automatic logic is_own(input logic [7:0] a);
    is_own = (a == DPM_ADDR_PTR_A_LOW) || (a == DPM_ADDR_PTR_A_HIGH) ||
             (a == DPM_ADDR_PTR_B_LOW) || (a == DPM_ADDR_PTR_B_HIGH) ||
             (a == DPM_ADDR_PTR_SELECT) || (a == DPM_ADDR_PAGE_HIGH) ||
             (a == DPM_ADDR_SOFT_FLAGS);
  endfunction

  function automatic logic is_flag_bit(input logic [7:0] a);
    is_flag_bit = a[7:3] == DPM_FLAG_BIT_BASE;
  endfunction

  dpm_space_dec u_dec (
    .map(map)
  );

  logic [15:0] ptr_next;

  always_comb begin
    st_nxt = st_r;
    ptr_next = active_ptr(st_r);

    // byte writes from the core; select register keeps only its one live bit
    if (sfr_wr) begin
      case (sfr_addr)
        DPM_ADDR_PTR_A_LOW: st_nxt.ptr_a[DPM_LOW_MSB:DPM_LOW_LSB] = sfr_wdata;
        DPM_ADDR_PTR_A_HIGH: st_nxt.ptr_a[DPM_HIGH_MSB:DPM_HIGH_LSB] = sfr_wdata;
        DPM_ADDR_PTR_B_LOW: st_nxt.ptr_b[DPM_LOW_MSB:DPM_LOW_LSB] = sfr_wdata;
        DPM_ADDR_PTR_B_HIGH: st_nxt.ptr_b[DPM_HIGH_MSB:DPM_HIGH_LSB] = sfr_wdata;
        // an increment is a read-modify-write of rdata+1; only its bit 0 is kept, which toggles sel
        DPM_ADDR_PTR_SELECT: st_nxt.sel = sfr_wdata[DPM_SEL_BIT];
        DPM_ADDR_PAGE_HIGH: st_nxt.page = sfr_wdata;
        DPM_ADDR_SOFT_FLAGS: st_nxt.flags = sfr_wdata;
        default: begin
        end
      endcase
    end

    // bit writes land after byte writes, so a same-cycle bit op wins
    if (bit_wr && is_flag_bit(bit_addr)) begin
      st_nxt.flags[bit_addr[2:0]] = bit_wval;
    end

    // pointer instructions touch only the pointer selected at that moment
    if (dptr_load) begin
      ptr_next = dptr_wdata;
    end else if (dptr_inc) begin
      ptr_next = active_ptr(st_r) + 16'h0001;
    end
    if (dptr_load || dptr_inc) begin
      if (st_r.sel) begin
        st_nxt.ptr_b = ptr_next;
      end else begin
        st_nxt.ptr_a = ptr_next;
      end
    end

    // reads return the value held before any write in the same cycle
    st_nxt.claim = sfr_rd && is_own(sfr_addr);
    st_nxt.rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        DPM_ADDR_PTR_A_LOW: st_nxt.rdata = st_r.ptr_a[DPM_LOW_MSB:DPM_LOW_LSB];
        DPM_ADDR_PTR_A_HIGH: st_nxt.rdata = st_r.ptr_a[DPM_HIGH_MSB:DPM_HIGH_LSB];
        DPM_ADDR_PTR_B_LOW: st_nxt.rdata = st_r.ptr_b[DPM_LOW_MSB:DPM_LOW_LSB];
        DPM_ADDR_PTR_B_HIGH: st_nxt.rdata = st_r.ptr_b[DPM_HIGH_MSB:DPM_HIGH_LSB];
        DPM_ADDR_PTR_SELECT: st_nxt.rdata = {7'h00, st_r.sel} & DPM_SELECT_MASK;
        DPM_ADDR_PAGE_HIGH: st_nxt.rdata = st_r.page;
        DPM_ADDR_SOFT_FLAGS: st_nxt.rdata = st_r.flags;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.bit_rdata = (bit_rd && is_flag_bit(bit_addr)) ? st_r.flags[bit_addr[2:0]] : 1'b0;

    // dptr_addr shows the post-update pointer; a move address uses the pointer held before this update
    st_nxt.dptr_addr = active_ptr(st_nxt);
    if (movx_req) begin
      if (movx_use_dptr) begin
        st_nxt.ext_addr = active_ptr(st_r);
      end else begin
        st_nxt.ext_addr = {st_r.page, movx_ri};
      end
    end

    map.code_addr = code_addr;
    map.idata_addr = idata_addr;
    map.idata_indirect = idata_indirect;
    map.xdata_addr = st_nxt.ext_addr;
    st_nxt.flash_hit = map.flash_hit;
    st_nxt.xram_hit = map.xram_hit;
    st_nxt.iram_lo = map.iram_lo;
    st_nxt.iram_hi = map.iram_hi;
    st_nxt.sfr_hit = map.sfr_hit;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= DPM_STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata_r = st_r.rdata;
  assign sfr_claim_r = st_r.claim;
  assign bit_rdata_r = st_r.bit_rdata;
  assign dptr_addr_r = st_r.dptr_addr;
  assign ext_addr_r = st_r.ext_addr;
  assign xram_hit_r = st_r.xram_hit;
  assign flash_hit_r = st_r.flash_hit;
  assign iram_lo_r = st_r.iram_lo;
  assign iram_hi_r = st_r.iram_hi;
  assign sfr_space_r = st_r.sfr_hit;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_inc_a_only;
    (!st_r.sel && dptr_inc && !dptr_load && !sfr_wr && !bit_wr) |=>
      (st_r.ptr_a == $past(st_r.ptr_a) + 16'h0001) && $stable(st_r.ptr_b);
  endproperty
  a_inc_a_only: assert property (p_inc_a_only) else $error("increment with select 0 misused pointers");

  property p_load_b_only;
    (st_r.sel && dptr_load && !sfr_wr) |=>
      (st_r.ptr_b == $past(dptr_wdata)) && $stable(st_r.ptr_a) && (dptr_addr_r == $past(dptr_wdata));
  endproperty
  a_load_b_only: assert property (p_load_b_only) else $error("load with select 1 misused pointers");

  property p_select_reads_zero_high;
    (sfr_rd && sfr_addr == DPM_ADDR_PTR_SELECT) |=> (sfr_rdata_r[7:1] == 7'h00) && sfr_claim_r;
  endproperty
  a_select_reads_zero_high: assert property (p_select_reads_zero_high) else $error("select upper bits not zero");

  property p_select_toggle;
    (sfr_wr && sfr_addr == DPM_ADDR_PTR_SELECT && sfr_wdata == {7'h00, st_r.sel} + 8'h01) |=>
      (st_r.sel != $past(st_r.sel)) ##1 (dptr_addr_r == (st_r.sel ? st_r.ptr_b : st_r.ptr_a));
  endproperty
  a_select_toggle: assert property (p_select_toggle) else $error("select increment did not toggle");

  property p_low_a_write;
    (sfr_wr && sfr_addr == DPM_ADDR_PTR_A_LOW && !(dptr_load || dptr_inc)) |=>
      (st_r.ptr_a[7:0] == $past(sfr_wdata)) && $stable(st_r.ptr_a[15:8]);
  endproperty
  a_low_a_write: assert property (p_low_a_write) else $error("first pointer low byte write lost");

  property p_high_b_readback;
    (sfr_wr && sfr_addr == DPM_ADDR_PTR_B_HIGH && !(dptr_load || dptr_inc)) ##1
      (sfr_rd && sfr_addr == DPM_ADDR_PTR_B_HIGH && !(dptr_load || dptr_inc)) |=>
      sfr_rdata_r == $past(sfr_wdata, 2);
  endproperty
  a_high_b_readback: assert property (p_high_b_readback) else $error("second pointer high byte readback wrong");

  property p_page_move;
    (movx_req && !movx_use_dptr) |=> (ext_addr_r == {$past(st_r.page), $past(movx_ri)});
  endproperty
  a_page_move: assert property (p_page_move) else $error("page move address wrong");

  // a byte store to f8h in the same cycle may legally move the other seven bits
  property p_flag_bit_write;
    (bit_wr && is_flag_bit(bit_addr) && !(sfr_wr && sfr_addr == DPM_ADDR_SOFT_FLAGS)) |=>
      (st_r.flags[$past(bit_addr[2:0])] == $past(bit_wval)) &&
      ((st_r.flags ^ $past(st_r.flags)) & ~(8'h01 << $past(bit_addr[2:0]))) == 8'h00;
  endproperty
  a_flag_bit_write: assert property (p_flag_bit_write) else $error("flag bit write wrong");

  property p_flag_byte_store;
    (sfr_wr && sfr_addr == DPM_ADDR_SOFT_FLAGS && !bit_wr) |=> st_r.flags == $past(sfr_wdata);
  endproperty
  a_flag_byte_store: assert property (p_flag_byte_store) else $error("flag byte store lost");

  property p_upper_split;
    (idata_addr >= DPM_IRAM_HALF) |=>
      (iram_hi_r == $past(idata_indirect)) && (sfr_space_r == !$past(idata_indirect)) && !iram_lo_r;
  endproperty
  a_upper_split: assert property (p_upper_split) else $error("upper internal half misrouted");

  property p_flash_fetch;
    (code_addr == 16'h0000) |=> flash_hit_r;
  endproperty
  a_flash_fetch: assert property (p_flash_fetch) else $error("reset vector not in flash");

  property p_xram_window;
    (movx_req && !movx_use_dptr && st_r.page < 8'h04) |=> xram_hit_r;
  endproperty
  a_xram_window: assert property (p_xram_window) else $error("on-chip external ram not decoded");

  property p_reset_state;
    $rose(reset_n) |-> (!st_r.sel && st_r.ptr_a == 16'h0000 && st_r.page == 8'h00 && st_r.flags == 8'h00);
  endproperty
  a_reset_state: assert property (@(posedge sys_clk) p_reset_state) else $error("reset state not zero");

  property p_load_a_only;
    (!st_r.sel && dptr_load && !sfr_wr) |=>
      (st_r.ptr_a == $past(dptr_wdata)) && $stable(st_r.ptr_b) && (dptr_addr_r == $past(dptr_wdata));
  endproperty
  a_load_a_only: assert property (p_load_a_only) else $error("load with select 0 misused pointers");

  property p_inc_b_only;
    (st_r.sel && dptr_inc && !dptr_load && !sfr_wr) |=>
      (st_r.ptr_b == $past(st_r.ptr_b) + 16'h0001) && $stable(st_r.ptr_a);
  endproperty
  a_inc_b_only: assert property (p_inc_b_only) else $error("increment with select 1 misused pointers");

  property p_high_a_write;
    (sfr_wr && sfr_addr == DPM_ADDR_PTR_A_HIGH && !(dptr_load || dptr_inc)) |=>
      (st_r.ptr_a[15:8] == $past(sfr_wdata)) && $stable(st_r.ptr_a[7:0]);
  endproperty
  a_high_a_write: assert property (p_high_a_write) else $error("first pointer high byte write lost");

  property p_select_store;
    (sfr_wr && sfr_addr == DPM_ADDR_PTR_SELECT) |=> (st_r.sel == $past(sfr_wdata[0]));
  endproperty
  a_select_store: assert property (p_select_store) else $error("select bit not taken from bit 0");

  // with the pointer as source the address is the pointer selected before this edge
  property p_dptr_move;
    (movx_req && movx_use_dptr) |=>
      (ext_addr_r == ($past(st_r.sel) ? $past(st_r.ptr_b) : $past(st_r.ptr_a)));
  endproperty
  a_dptr_move: assert property (p_dptr_move) else $error("pointer move address wrong");

  property p_page_store;
    (sfr_wr && sfr_addr == DPM_ADDR_PAGE_HIGH) |=> (st_r.page == $past(sfr_wdata));
  endproperty
  a_page_store: assert property (p_page_store) else $error("page register store lost");

  property p_flag_bit_read;
    (bit_rd && is_flag_bit(bit_addr)) |=>
      (bit_rdata_r == ((($past(st_r.flags) >> $past(bit_addr[2:0])) & 8'h01) != 8'h00));
  endproperty
  a_flag_bit_read: assert property (p_flag_bit_read) else $error("flag bit read wrong");

  property p_lower_half;
    (idata_addr < DPM_IRAM_HALF) |=> iram_lo_r && !iram_hi_r && !sfr_space_r;
  endproperty
  a_lower_half: assert property (p_lower_half) else $error("lower internal half misrouted");

  c_toggle: cover property (sfr_wr && sfr_addr == DPM_ADDR_PTR_SELECT ##1 dptr_inc);
  c_page_move: cover property (movx_req && !movx_use_dptr && movx_ri == 8'hff);
  c_flag_set: cover property (bit_wr && is_flag_bit(bit_addr) && bit_wval);
  c_b_increment: cover property (st_r.sel && dptr_inc);
  c_b_move: cover property (st_r.sel && movx_req && movx_use_dptr);

endmodule

//--- dpm_space_dec.sv
`timescale 1ns/1ps
module dpm_space_dec
  import dpm_pkg::*;
(
  dpm_map_if.dec map
);

  always_comb begin
    // code space below the flash size fetches from flash, vector 0 included
    map.flash_hit = {1'b0, map.code_addr} < DPM_FLASH_BYTES;
    // only the first kilobyte of external data space is backed on chip
    map.xram_hit = {1'b0, map.xdata_addr} < DPM_XRAM_BYTES;
    map.iram_lo = map.idata_addr < DPM_IRAM_HALF;
    // the upper half splits on addressing mode: direct reaches sfrs, indirect the upper ram
    map.iram_hi = (map.idata_addr >= DPM_IRAM_HALF) && map.idata_indirect;
    map.sfr_hit = (map.idata_addr >= DPM_IRAM_HALF) && !map.idata_indirect;
  end

endmodule

//--- dual_pointer_memory_regs_tb_top.sv
`timescale 1ns/1ps
module dual_pointer_memory_regs_tb_top import dpm_pkg::*;;
  logic sys_clk, reset_n, sfr_wr, sfr_rd, sfr_claim_r, bit_wr, bit_wval, bit_rd, bit_rdata_r;
  logic dptr_load, dptr_inc, movx_req, movx_use_dptr, xram_hit_r, idata_indirect;
  logic flash_hit_r, iram_lo_r, iram_hi_r, sfr_space_r;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, page, flags;
  logic [15:0] dptr_wdata, dptr_addr_r, ext_addr_r, code_addr, pa, pb;
  logic sel;
  logic [3:0] op, op_d;
  logic [32:0] expq[$];
  logic [32:0] got, exp_v;
  logic [7:0] regs[7] = '{DPM_ADDR_PTR_A_LOW, DPM_ADDR_PTR_A_HIGH, DPM_ADDR_PTR_B_LOW, DPM_ADDR_PTR_B_HIGH,
                          DPM_ADDR_PTR_SELECT, DPM_ADDR_PAGE_HIGH, DPM_ADDR_SOFT_FLAGS};
  int num_errors, total_checks;
  integer seed, r;

  dpm_core_model core (.sys_clk(sys_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .bit_wr(bit_wr), .bit_wval(bit_wval), .bit_rd(bit_rd), .dptr_load(dptr_load),
    .dptr_wdata(dptr_wdata), .dptr_inc(dptr_inc), .movx_req(movx_req), .movx_use_dptr(movx_use_dptr),
    .code_addr(code_addr), .idata_indirect(idata_indirect), .op(op));

  dpm_regs DUT (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_r(sfr_rdata_r), .sfr_claim_r(sfr_claim_r),
    .bit_addr(sfr_addr), .bit_wr(bit_wr), .bit_wval(bit_wval), .bit_rd(bit_rd), .bit_rdata_r(bit_rdata_r),
    .dptr_load(dptr_load), .dptr_wdata(dptr_wdata), .dptr_inc(dptr_inc), .dptr_addr_r(dptr_addr_r),
    .movx_req(movx_req), .movx_use_dptr(movx_use_dptr), .movx_ri(sfr_addr), .ext_addr_r(ext_addr_r),
    .xram_hit_r(xram_hit_r), .code_addr(code_addr), .flash_hit_r(flash_hit_r), .idata_addr(sfr_addr),
    .idata_indirect(idata_indirect), .iram_lo_r(iram_lo_r), .iram_hi_r(iram_hi_r), .sfr_space_r(sfr_space_r));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [8:0] rv(input logic [7:0] a);
    case (a)
      DPM_ADDR_PTR_A_LOW: rv = {1'b1, pa[7:0]};
      DPM_ADDR_PTR_A_HIGH: rv = {1'b1, pa[15:8]};
      DPM_ADDR_PTR_B_LOW: rv = {1'b1, pb[7:0]};
      DPM_ADDR_PTR_B_HIGH: rv = {1'b1, pb[15:8]};
      DPM_ADDR_PTR_SELECT: rv = {1'b1, 7'h00, sel};
      DPM_ADDR_PAGE_HIGH: rv = {1'b1, page};
      DPM_ADDR_SOFT_FLAGS: rv = {1'b1, flags};
      default: rv = 9'h000;
    endcase
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    core.go(4'h1, a, {8'h00, d});
    case (a)
      DPM_ADDR_PTR_A_LOW: pa[7:0] = d;
      DPM_ADDR_PTR_A_HIGH: pa[15:8] = d;
      DPM_ADDR_PTR_B_LOW: pb[7:0] = d;
      DPM_ADDR_PTR_B_HIGH: pb[15:8] = d;
      DPM_ADDR_PTR_SELECT: sel = d[0];
      DPM_ADDR_PAGE_HIGH: page = d;
      DPM_ADDR_SOFT_FLAGS: flags = d;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    core.go(4'h2, a, 16'h0000);
    expq.push_back({24'h000000, rv(a)});
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    core.go(4'h3, a, {15'h0000, v});
    if (a >= 8'hf8) flags[a[2:0]] = v;
  endtask
  task automatic br(input logic [7:0] a);
    core.go(4'h4, a, 16'h0000);
    expq.push_back({32'h00000000, a >= 8'hf8 && flags[a[2:0]]});
  endtask
  task automatic ld(input logic [15:0] d);
    core.go(4'h5, 8'h00, d);
    if (sel) pb = d;
    else pa = d;
  endtask
  task automatic inc();
    core.go(4'h6, 8'h00, 16'h0000);
    if (sel) pb = pb + 16'h0001;
    else pa = pa + 16'h0001;
  endtask
  task automatic mx(input logic ud, input logic [7:0] ri);
    logic [15:0] a;
    a = ud ? (sel ? pb : pa) : {page, ri};
    core.go(ud ? 4'h8 : 4'h7, ri, 16'h0000);
    expq.push_back({(sel ? pb : pa), a < 16'h0400, a});
  endtask
  task automatic dec(input logic [15:0] c, input logic [7:0] ia);
    core.go(4'h9, ia, c);
    expq.push_back({29'h00000000, c < 16'he000, ia < 8'h80, ia >= 8'h80 && c[0], ia >= 8'h80 && !c[0]});
  endtask
  // idle the core first so a held read strobe does not keep producing results
  task automatic drain();
    core.go(4'h0, 8'h00, 16'h0000);
    for (int i = 0; i < 8 && expq.size() != 0; i++) @(negedge sys_clk);
    if (expq.size() != 0) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, expq.size(), 0);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    {pa, pb, sel, page, flags} = '0;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
  endtask

  always @(posedge sys_clk) op_d <= op;
  always @(negedge sys_clk) begin
    if (reset_n && op_d inside {4'h2, 4'h4, 4'h7, 4'h8, 4'h9}) begin
      case (op_d)
        4'h2: got = {24'h000000, sfr_claim_r, sfr_rdata_r};
        4'h4: got = {32'h00000000, bit_rdata_r};
        4'h9: got = {29'h00000000, flash_hit_r, iram_lo_r, iram_hi_r, sfr_space_r};
        default: got = {dptr_addr_r, xram_hit_r, ext_addr_r};
      endcase
      exp_v = expq.size() != 0 ? expq.pop_front() : ~got;
      total_checks++;
      if (got !== exp_v) begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp_v);
      end
    end
  end

  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    seed = 32'h10b4;
    num_errors = 0;
    total_checks = 0;
    do_reset();
    foreach (regs[i]) rd(regs[i]);
    rd(8'h80);
    foreach (regs[i]) begin
      r = $random(seed);
      wr(regs[i], r[7:0]);
      rd(regs[i]);
    end
    for (int i = 0; i < 3; i++) begin
      rd(DPM_ADDR_PTR_SELECT);
      wr(DPM_ADDR_PTR_SELECT, {7'h00, sel} + 8'h01);
      inc();
      mx(1'b1, 8'h00);
    end
    for (int s = 0; s < 2; s++) begin
      wr(DPM_ADDR_PTR_SELECT, s[7:0]);
      ld(16'hfffe);
      inc();
      inc();
      mx(1'b1, 8'h00);
      rd(DPM_ADDR_PTR_A_HIGH);
      rd(DPM_ADDR_PTR_B_LOW);
      r = $random(seed);
      ld(r[15:0]);
      mx(1'b1, 8'h00);
    end
    wr(DPM_ADDR_PAGE_HIGH, 8'h03);
    mx(1'b0, 8'h40);
    mx(1'b0, 8'hff);
    wr(DPM_ADDR_PAGE_HIGH, 8'h04);
    mx(1'b0, 8'h00);
    r = $random(seed);
    wr(DPM_ADDR_PAGE_HIGH, r[15:8]);
    mx(1'b0, r[7:0]);
    for (int n = 0; n < 8; n++) begin
      r = $random(seed);
      bw(8'hf8 + n[7:0], r[0]);
      br(8'hf8 + n[7:0]);
    end
    rd(DPM_ADDR_SOFT_FLAGS);
    bw(8'h20, 1'b1);
    br(8'h20);
    rd(DPM_ADDR_SOFT_FLAGS);
    dec(16'hdfff, 8'h80);
    dec(16'he000, 8'h80);
    dec(16'hdffe, 8'h7f);
    dec(16'he001, 8'h7f);
    drain();
    do_reset();
    foreach (regs[i]) rd(regs[i]);
    drain();
    end_of_test();
  end
endmodule
